// *** common/cpuexc_defines.vh ***
`ifndef CPUEXC_DEFINES_VH
`define CPUEXC_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define CPUEXC_IDX_PRIORITY_LEVEL_LOAD 6'h12
`define CPUEXC_IDX_SOFTWARE_INTERRUPT_REQUEST 6'h14
`define CPUEXC_IDX_SOFTWARE_INTERRUPT_SUMMARY 6'h15
`define CPUEXC_ADDR_PRIORITY_LEVEL_LOAD 8'h48
`define CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST 8'h50
`define CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY 8'h54
`define CPUEXC_ADDR_STATUS_LONGWORD 8'h80
`define CPUEXC_ADDR_EXC_STATUS 8'h84
`define CPUEXC_ADDR_SAVED_PC 8'h88
`define CPUEXC_ADDR_FRAME_COUNT 8'h8c
`define CPUEXC_ADDR_FRAME_CODE 8'h90
`define CPUEXC_ADDR_FRAME_CLEAR 8'h94

// Status longword fields
`define CPUEXC_PSL_IPL_HI 20
`define CPUEXC_PSL_IPL_LO 16
`define CPUEXC_IPL_SYSFAIL 5'h1f
`define CPUEXC_PSL_RESET 32'h041f0000

// Frame fields
`define CPUEXC_MC_BYTE_COUNT 32'h00000018
`define CPUEXC_MC_RESTART_BIT 31
`define CPUEXC_MC_PARAM_WORDS 4'h8

// Exception types
`define CPUEXC_TYPE_TRAP 2'h0
`define CPUEXC_TYPE_FAULT 2'h1
`define CPUEXC_TYPE_ABORT 2'h2

// Exception cause selects
`define CPUEXC_C_INT_OVF 5'h00
`define CPUEXC_C_INT_DIV 5'h01
`define CPUEXC_C_SUBRNG 5'h02
`define CPUEXC_C_FLT_OVF 5'h03
`define CPUEXC_C_FLT_DIV 5'h04
`define CPUEXC_C_FLT_UND 5'h05
`define CPUEXC_C_ACV 5'h06
`define CPUEXC_C_TNV 5'h07
`define CPUEXC_C_RADDR 5'h08
`define CPUEXC_C_ROPRND 5'h09
`define CPUEXC_C_RPRIV 5'h0a
`define CPUEXC_C_EMUL_START 5'h0b
`define CPUEXC_C_EMUL_CONT 5'h0c
`define CPUEXC_C_CHMK 5'h0d
`define CPUEXC_C_CHME 5'h0e
`define CPUEXC_C_CHMS 5'h0f
`define CPUEXC_C_CHMU 5'h10
`define CPUEXC_C_BPT 5'h11
`define CPUEXC_C_TRACE 5'h12
`define CPUEXC_C_CONSOLE 5'h13
`define CPUEXC_C_INTSTK 5'h14
`define CPUEXC_C_KSTK 5'h15
`define CPUEXC_C_MCHK 5'h16

// Vector offsets
`define CPUEXC_V_ARITH 8'h34
`define CPUEXC_V_ACV 8'h20
`define CPUEXC_V_TNV 8'h24
`define CPUEXC_V_RADDR 8'h1c
`define CPUEXC_V_ROPRND 8'h18
`define CPUEXC_V_RPRIV 8'h10
`define CPUEXC_V_EMUL_START 8'hc8
`define CPUEXC_V_EMUL_CONT 8'hcc
`define CPUEXC_V_CHMK 8'h40
`define CPUEXC_V_CHME 8'h44
`define CPUEXC_V_CHMS 8'h48
`define CPUEXC_V_CHMU 8'h4c
`define CPUEXC_V_BPT 8'h2c
`define CPUEXC_V_TRACE 8'h28
`define CPUEXC_V_KSTK 8'h08
`define CPUEXC_V_MCHK 8'h04
`define CPUEXC_V_NONE 8'h00

// Machine check codes
`define CPUEXC_MC_FP_PROTO 16'h0001
`define CPUEXC_MC_FP_OPC 16'h0002
`define CPUEXC_MC_FP_OPPAR 16'h0003
`define CPUEXC_MC_FP_STAT 16'h0004
`define CPUEXC_MC_FP_RESPAR 16'h0005
`define CPUEXC_MC_MM_MISS 16'h0008
`define CPUEXC_MC_MM_HIT 16'h0009
`define CPUEXC_MC_IPL_UNUSED 16'h000a
`define CPUEXC_MC_UC_STRING 16'h000b
`define CPUEXC_MC_UC_TRAP 16'h000c
`define CPUEXC_MC_UC_CSADDR 16'h000d
`define CPUEXC_MC_RD_CACHE 16'h0010
`define CPUEXC_MC_RD_BUS 16'h0011
`define CPUEXC_MC_WR_BUS 16'h0012
`define CPUEXC_MC_BUS_UNDEF 16'h0013
`define CPUEXC_MC_SRC_COUNT 15

`endif

// *** hdl/cpuexc_unit.v ***
`timescale 1ns/1ns
`include "cpuexc_defines.vh"

// Functional notes
// - Priority register write loads status bits 20:16
// - Request writes set summary pending levels 1-15
// - Trap saves next instruction address
// - Fault saves faulting instruction address
// - Abort saves address of aborted instruction
// - Save PC/status; system failure raises level 1f
// - Console, bad interrupt stack or nested exception goes firmware
// - Vector offsets per cause class table
// - Machine check frame: status, PC, params, count
// - Byte count longword holds 24
// - Restart bit set when no state changed
// - Low 16 bits hold machine check code
// - Floating coprocessor errors codes 01 to 05
// - Translation miss 08, hit 09
// - Unused interrupt level gives code 0a
// - Microcode inconsistencies codes 0b 0c 0d
// - Read cache error 10, bus error 11
// - Write bus error gives code 12
// - Undefined bus state gives code 13
module cpuexc_unit (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire i_exc_valid,
  input wire [4:0] i_exc_cause,
  input wire [31:0] i_cur_pc,
  input wire [31:0] i_next_pc,
  input wire [31:0] i_abort_pc,
  input wire i_in_service,
  input wire [`CPUEXC_MC_SRC_COUNT-1:0] i_mc_src,
  input wire i_state_changed,
  input wire [31:0] i_mc_param,
  output reg o_exc_taken,
  output reg [1:0] o_exc_type,
  output reg [7:0] o_vector,
  output reg o_to_firmware,
  output reg [31:0] o_saved_pc,
  output reg [31:0] o_saved_psl,
  output reg [4:0] o_priority_level,
  output reg [15:1] o_soft_pending,
  output reg o_frame_valid,
  output reg [3:0] o_frame_index,
  output reg [31:0] o_frame_data
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PUSH = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [31:0] psl_q;
  reg [31:0] psl_d;
  reg [15:1] software_interrupt_summary_q;
  reg [15:1] software_interrupt_summary_d;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] idx_q;
  reg [3:0] idx_d;
  reg [15:0] code_q;
  reg restart_q;
  reg [31:0] mc_pc_q;
  reg [31:0] mc_psl_q;
  reg [31:0] param_q;
  reg [31:0] frame_word;
  reg [15:0] mc_code;
  reg mc_any;
  reg [1:0] etype;
  reg [7:0] evec;
  reg [31:0] epc;
  reg sysfail;
  reg fw;
  reg take;
  integer k;

  wire wr_acc = i_psel & i_penable & i_pwrite;

  // Shared decode for exception class type
  function [1:0] cause_type;
    input [4:0] c;
    begin
      case (c)
        `CPUEXC_C_INT_OVF, `CPUEXC_C_INT_DIV, `CPUEXC_C_SUBRNG,
        `CPUEXC_C_CHMK, `CPUEXC_C_CHME, `CPUEXC_C_CHMS, `CPUEXC_C_CHMU:
          cause_type = `CPUEXC_TYPE_TRAP;
        `CPUEXC_C_CONSOLE, `CPUEXC_C_INTSTK, `CPUEXC_C_KSTK, `CPUEXC_C_MCHK:
          cause_type = `CPUEXC_TYPE_ABORT;
        default:
          cause_type = `CPUEXC_TYPE_FAULT;
      endcase
    end
  endfunction

  // Shared decode for cause to control-block vector
  function [7:0] cause_vec;
    input [4:0] c;
    begin
      case (c)
        `CPUEXC_C_INT_OVF, `CPUEXC_C_INT_DIV, `CPUEXC_C_SUBRNG,
        `CPUEXC_C_FLT_OVF, `CPUEXC_C_FLT_DIV, `CPUEXC_C_FLT_UND:
          cause_vec = `CPUEXC_V_ARITH;
        `CPUEXC_C_ACV: cause_vec = `CPUEXC_V_ACV;
        `CPUEXC_C_TNV: cause_vec = `CPUEXC_V_TNV;
        `CPUEXC_C_RADDR: cause_vec = `CPUEXC_V_RADDR;
        `CPUEXC_C_ROPRND: cause_vec = `CPUEXC_V_ROPRND;
        `CPUEXC_C_RPRIV: cause_vec = `CPUEXC_V_RPRIV;
        `CPUEXC_C_EMUL_START: cause_vec = `CPUEXC_V_EMUL_START;
        `CPUEXC_C_EMUL_CONT: cause_vec = `CPUEXC_V_EMUL_CONT;
        `CPUEXC_C_CHMK: cause_vec = `CPUEXC_V_CHMK;
        `CPUEXC_C_CHME: cause_vec = `CPUEXC_V_CHME;
        `CPUEXC_C_CHMS: cause_vec = `CPUEXC_V_CHMS;
        `CPUEXC_C_CHMU: cause_vec = `CPUEXC_V_CHMU;
        `CPUEXC_C_BPT: cause_vec = `CPUEXC_V_BPT;
        `CPUEXC_C_TRACE: cause_vec = `CPUEXC_V_TRACE;
        `CPUEXC_C_KSTK: cause_vec = `CPUEXC_V_KSTK;
        `CPUEXC_C_MCHK: cause_vec = `CPUEXC_V_MCHK;
        default: cause_vec = `CPUEXC_V_NONE;
      endcase
    end
  endfunction

  // Code table indexed by source bit; low index is earlier in the pipeline
  function [15:0] src_code;
    input [3:0] s;
    begin
      case (s)
        4'h0: src_code = `CPUEXC_MC_FP_PROTO;
        4'h1: src_code = `CPUEXC_MC_FP_OPC;
        4'h2: src_code = `CPUEXC_MC_FP_OPPAR;
        4'h3: src_code = `CPUEXC_MC_FP_STAT;
        4'h4: src_code = `CPUEXC_MC_FP_RESPAR;
        4'h5: src_code = `CPUEXC_MC_MM_MISS;
        4'h6: src_code = `CPUEXC_MC_MM_HIT;
        4'h7: src_code = `CPUEXC_MC_IPL_UNUSED;
        4'h8: src_code = `CPUEXC_MC_UC_STRING;
        4'h9: src_code = `CPUEXC_MC_UC_TRAP;
        4'ha: src_code = `CPUEXC_MC_UC_CSADDR;
        4'hb: src_code = `CPUEXC_MC_RD_CACHE;
        4'hc: src_code = `CPUEXC_MC_RD_BUS;
        4'hd: src_code = `CPUEXC_MC_WR_BUS;
        4'he: src_code = `CPUEXC_MC_BUS_UNDEF;
        default: src_code = 16'h0000;
      endcase
    end
  endfunction

  // Descending scan so the lowest set source is the one kept
  always @* begin
    mc_code = 16'h0000;
    mc_any = 1'b0;
    for (k = `CPUEXC_MC_SRC_COUNT - 1; k >= 0; k = k - 1) begin
      if (i_mc_src[k]) begin
        mc_code = src_code(k[3:0]);
        mc_any = 1'b1;
      end
    end
  end

  always @* begin
    etype = cause_type(i_exc_cause);
    evec = cause_vec(i_exc_cause);
    sysfail = (i_exc_cause == `CPUEXC_C_CONSOLE) | (i_exc_cause == `CPUEXC_C_INTSTK) |
              (i_exc_cause == `CPUEXC_C_KSTK) | (i_exc_cause == `CPUEXC_C_MCHK);
    fw = (i_exc_cause == `CPUEXC_C_CONSOLE) | (i_exc_cause == `CPUEXC_C_INTSTK) | i_in_service;
    case (etype)
      `CPUEXC_TYPE_TRAP: epc = i_next_pc;
      `CPUEXC_TYPE_FAULT: epc = i_cur_pc;
      default: epc = i_abort_pc;
    endcase
    // A frame push in progress, or its done cycle, blocks new exceptions; requests are not held
    take = (state_q == ST_IDLE) & (i_exc_valid | mc_any);
  end

  always @* begin
    psl_d = psl_q;
    if (wr_acc && i_paddr == `CPUEXC_ADDR_PRIORITY_LEVEL_LOAD) begin
      psl_d[`CPUEXC_PSL_IPL_HI:`CPUEXC_PSL_IPL_LO] = i_pwdata[4:0];
    end
    if (wr_acc && i_paddr == `CPUEXC_ADDR_STATUS_LONGWORD) begin
      psl_d = i_pwdata;
    end
    if (take && (mc_any || sysfail)) begin
      psl_d[`CPUEXC_PSL_IPL_HI:`CPUEXC_PSL_IPL_LO] = `CPUEXC_IPL_SYSFAIL;
    end
  end

  always @* begin
    software_interrupt_summary_d = software_interrupt_summary_q;
    if (wr_acc && i_paddr == `CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY) begin
      software_interrupt_summary_d = i_pwdata[15:1];
    end
    if (wr_acc && i_paddr == `CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST && i_pwdata[3:0] != 4'h0) begin
      software_interrupt_summary_d[i_pwdata[3:0]] = 1'b1;
    end
  end

  always @* begin
    state_d = state_q;
    idx_d = idx_q;
    case (state_q)
      ST_IDLE: begin
        if (take && mc_any) begin
          state_d = ST_PUSH;
          idx_d = 4'h0;
        end
      end
      ST_PUSH: begin
        if (idx_q == `CPUEXC_MC_PARAM_WORDS + 4'h3) begin
          state_d = ST_DONE;
        end else begin
          idx_d = idx_q + 4'h1;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Frame order from the top of stack: count, code word, params, PC, status
  always @* begin
    if (idx_q == 4'h0) begin
      frame_word = `CPUEXC_MC_BYTE_COUNT;
    end else if (idx_q == 4'h1) begin
      frame_word = {restart_q, 15'h0000, code_q};
    end else if (idx_q == `CPUEXC_MC_PARAM_WORDS + 4'h2) begin
      frame_word = mc_pc_q;
    end else if (idx_q == `CPUEXC_MC_PARAM_WORDS + 4'h3) begin
      frame_word = mc_psl_q;
    end else begin
      frame_word = param_q;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psl_q <= `CPUEXC_PSL_RESET;
      software_interrupt_summary_q <= 15'h0000;
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      code_q <= 16'h0000;
      restart_q <= 1'b0;
      mc_pc_q <= 32'h00000000;
      mc_psl_q <= 32'h00000000;
      param_q <= 32'h00000000;
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      o_exc_taken <= 1'b0;
      o_exc_type <= 2'h0;
      o_vector <= 8'h00;
      o_to_firmware <= 1'b0;
      o_saved_pc <= 32'h00000000;
      o_saved_psl <= 32'h00000000;
      o_priority_level <= 5'h1f;
      o_soft_pending <= 15'h0000;
      o_frame_valid <= 1'b0;
      o_frame_index <= 4'h0;
      o_frame_data <= 32'h00000000;
    end else begin
      psl_q <= psl_d;
      software_interrupt_summary_q <= software_interrupt_summary_d;
      state_q <= state_d;
      idx_q <= idx_d;
      param_q <= i_mc_param;
      o_priority_level <= psl_d[`CPUEXC_PSL_IPL_HI:`CPUEXC_PSL_IPL_LO];
      o_soft_pending <= software_interrupt_summary_d;
      o_exc_taken <= take;
      // Clear goes first so a capture in the same cycle is not lost
      if (wr_acc && i_paddr == `CPUEXC_ADDR_FRAME_CLEAR) begin
        code_q <= 16'h0000;
        restart_q <= 1'b0;
      end
      if (take) begin
        o_saved_psl <= psl_q;
        o_to_firmware <= fw;
        if (mc_any) begin
          o_exc_type <= `CPUEXC_TYPE_ABORT;
          o_vector <= fw ? `CPUEXC_V_NONE : `CPUEXC_V_MCHK;
          o_saved_pc <= i_abort_pc;
          code_q <= mc_code;
          restart_q <= ~i_state_changed;
          mc_pc_q <= i_abort_pc;
          mc_psl_q <= psl_q;
        end else begin
          o_exc_type <= etype;
          o_vector <= fw ? `CPUEXC_V_NONE : evec;
          o_saved_pc <= epc;
        end
      end
      o_frame_valid <= (state_q == ST_PUSH);
      o_frame_index <= idx_q;
      o_frame_data <= frame_word;
      // Zero wait-state slave; data registered in the setup cycle for the access cycle
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        case (i_paddr)
          `CPUEXC_ADDR_PRIORITY_LEVEL_LOAD: o_prdata <= {27'h0000000, psl_q[20:16]};
          `CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY: o_prdata <= {16'h0000, software_interrupt_summary_q, 1'b0};
          `CPUEXC_ADDR_STATUS_LONGWORD: o_prdata <= psl_q;
          `CPUEXC_ADDR_EXC_STATUS: o_prdata <= {30'h00000000, state_q};
          `CPUEXC_ADDR_SAVED_PC: o_prdata <= o_saved_pc;
          `CPUEXC_ADDR_FRAME_COUNT: o_prdata <= `CPUEXC_MC_BYTE_COUNT;
          `CPUEXC_ADDR_FRAME_CODE: o_prdata <= {restart_q, 15'h0000, code_q};
          default: o_prdata <= 32'h00000000;
        endcase
      end
      if (i_psel & ~i_penable) begin
        case (i_paddr)
          `CPUEXC_ADDR_PRIORITY_LEVEL_LOAD, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST,
          `CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY, `CPUEXC_ADDR_STATUS_LONGWORD,
          `CPUEXC_ADDR_EXC_STATUS, `CPUEXC_ADDR_SAVED_PC, `CPUEXC_ADDR_FRAME_COUNT,
          `CPUEXC_ADDR_FRAME_CODE, `CPUEXC_ADDR_FRAME_CLEAR: o_pslverr <= 1'b0;
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// *** tb/cpuexc_unit_properties.sv ***
`timescale 1ns/1ns
`include "cpuexc_defines.vh"
module cpuexc_unit_properties (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire i_exc_valid,
  input wire [`CPUEXC_MC_SRC_COUNT-1:0] i_mc_src,
  input wire [31:0] i_cur_pc,
  input wire [31:0] i_next_pc,
  input wire [31:0] i_abort_pc,
  input wire o_exc_taken,
  input wire [1:0] o_exc_type,
  input wire [7:0] o_vector,
  input wire o_to_firmware,
  input wire [31:0] o_saved_pc,
  input wire [4:0] o_priority_level,
  input wire o_frame_valid,
  input wire [3:0] o_frame_index,
  input wire [31:0] o_frame_data
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_mc_take;
    o_exc_taken && o_vector == `CPUEXC_V_MCHK;
  endsequence
  // Count word first, then the code word that software parses
  sequence s_frame_head;
    o_frame_valid && o_frame_index == 4'h0 && o_frame_data == `CPUEXC_MC_BYTE_COUNT ##1 o_frame_valid && o_frame_index == 4'h1;
  endsequence
  property p_ready_access;
    i_psel && !i_penable |=> o_pready;
  endproperty
  property p_taken_cause;
    o_exc_taken |-> $past(i_exc_valid || (|i_mc_src));
  endproperty
  property p_trap_pc;
    o_exc_taken && o_exc_type == `CPUEXC_TYPE_TRAP |-> o_saved_pc == $past(i_next_pc);
  endproperty
  property p_fault_pc;
    o_exc_taken && o_exc_type == `CPUEXC_TYPE_FAULT |-> o_saved_pc == $past(i_cur_pc);
  endproperty
  property p_abort_pc;
    o_exc_taken && o_exc_type == `CPUEXC_TYPE_ABORT |-> o_saved_pc == $past(i_abort_pc);
  endproperty
  property p_sysfail_level;
    o_exc_taken && (o_vector == `CPUEXC_V_MCHK || o_vector == `CPUEXC_V_KSTK) |-> o_priority_level == 5'h1f;
  endproperty
  property p_level_keep;
    o_exc_taken && o_exc_type != `CPUEXC_TYPE_ABORT && !$past(i_psel && i_penable && i_pwrite)
      |-> o_priority_level == $past(o_priority_level);
  endproperty
  property p_fw_vector;
    o_exc_taken && o_to_firmware |-> o_vector == `CPUEXC_V_NONE;
  endproperty
  property p_mc_frame;
    s_mc_take |=> s_frame_head;
  endproperty
  property p_frame_step;
    o_frame_valid && o_frame_index != 4'hb |=> o_frame_valid && o_frame_index == $past(o_frame_index) + 4'h1;
  endproperty
  property p_ipl_write;
    i_psel && i_penable && i_pwrite && o_pready && i_paddr == `CPUEXC_ADDR_PRIORITY_LEVEL_LOAD && !i_exc_valid
      && i_mc_src == 0 |=> o_priority_level == $past(i_pwdata[4:0]);
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready missing in access cycle");
  a_taken_cause: assert property (p_taken_cause)
    else $error("exception taken without request");
  a_trap_pc: assert property (p_trap_pc)
    else $error("trap saved pc wrong");
  a_fault_pc: assert property (p_fault_pc)
    else $error("fault saved pc wrong");
  a_abort_pc: assert property (p_abort_pc)
    else $error("abort saved pc wrong");
  a_sysfail_level: assert property (p_sysfail_level)
    else $error("system failure level not raised");
  a_level_keep: assert property (p_level_keep)
    else $error("priority level changed by exception");
  a_fw_vector: assert property (p_fw_vector)
    else $error("firmware dispatch with vector");
  a_mc_frame: assert property (p_mc_frame)
    else $error("frame head wrong");
  a_frame_step: assert property (p_frame_step)
    else $error("frame index skipped");
  a_ipl_write: assert property (p_ipl_write)
    else $error("priority write not loaded");
endmodule

// *** tb/cpuexc_unit_tb.sv ***
`timescale 1ns/1ns
`include "cpuexc_defines.vh"
module cpuexc_unit_tb;
  logic i_clock, i_rst_n, i_psel, i_penable, i_pwrite, i_exc_valid, i_in_service, i_state_changed;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, i_cur_pc, i_next_pc, i_abort_pc, i_mc_param;
  logic [4:0] i_exc_cause;
  logic [14:0] i_mc_src;
  logic o_pready, o_pslverr, o_exc_taken, o_to_firmware, o_frame_valid;
  logic [31:0] o_prdata, o_saved_pc, o_saved_psl, o_frame_data, rd;
  logic [1:0] o_exc_type;
  logic [7:0] o_vector;
  logic [4:0] o_priority_level;
  logic [15:1] o_soft_pending;
  logic [3:0] o_frame_index;
  logic [31:0] frame [0:11];
  logic err;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int late_takes;
  localparam logic [119:0] MC_CODES = 120'h13_12_11_10_0d_0c_0b_0a_09_08_05_04_03_02_01;
  cpuexc_unit uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_exc_valid(i_exc_valid), .i_exc_cause(i_exc_cause), .i_cur_pc(i_cur_pc),
    .i_next_pc(i_next_pc), .i_abort_pc(i_abort_pc), .i_in_service(i_in_service), .i_mc_src(i_mc_src),
    .i_state_changed(i_state_changed), .i_mc_param(i_mc_param), .o_exc_taken(o_exc_taken),
    .o_exc_type(o_exc_type), .o_vector(o_vector), .o_to_firmware(o_to_firmware), .o_saved_pc(o_saved_pc),
    .o_saved_psl(o_saved_psl), .o_priority_level(o_priority_level), .o_soft_pending(o_soft_pending),
    .o_frame_valid(o_frame_valid), .o_frame_index(o_frame_index), .o_frame_data(o_frame_data));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task complete_run;
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A hung handshake is cut here rather than in every wait loop
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task req(input logic v, input logic [4:0] c, input logic [14:0] m, input logic svc);
    @(posedge i_clock);
    i_exc_valid <= v;
    i_exc_cause <= c;
    i_mc_src <= m;
    i_in_service <= svc;
    i_cur_pc <= {27'h100, c};
    i_next_pc <= {27'h200, c};
    i_abort_pc <= {27'h300, c};
    @(posedge i_clock);
    i_exc_valid <= 1'b0;
    i_mc_src <= 15'h0;
    do @(posedge i_clock); while (o_exc_taken !== 1'b1);
  endtask
  function automatic logic [10:0] exp_of(input logic [4:0] c);
    case (c)
      5'h00, 5'h01, 5'h02: exp_of = {3'h0, 8'h34};
      5'h03, 5'h04, 5'h05: exp_of = {3'h1, 8'h34};
      5'h06: exp_of = {3'h1, 8'h20};
      5'h07: exp_of = {3'h1, 8'h24};
      5'h08: exp_of = {3'h1, 8'h1c};
      5'h09: exp_of = {3'h3, 8'h18};
      5'h0a: exp_of = {3'h1, 8'h10};
      5'h0b: exp_of = {3'h1, 8'hc8};
      5'h0c: exp_of = {3'h1, 8'hcc};
      5'h0d, 5'h0e, 5'h0f, 5'h10: exp_of = {3'h0, 8'h40 + {1'b0, c - 5'h0d, 2'b00}};
      5'h11: exp_of = {3'h1, 8'h2c};
      5'h12: exp_of = {3'h1, 8'h28};
      5'h15: exp_of = {3'h2, 8'h08};
      default: exp_of = {3'h6, 8'h00};
    endcase
  endfunction
  task t_regs;
    check(o_priority_level, 32'h1f);
    apb(1'b0, `CPUEXC_ADDR_STATUS_LONGWORD, 32'h0);
    check(rd, `CPUEXC_PSL_RESET);
    apb(1'b1, `CPUEXC_ADDR_PRIORITY_LEVEL_LOAD, 32'h0d);
    check(o_priority_level, 32'h0d);
    apb(1'b0, `CPUEXC_ADDR_STATUS_LONGWORD, 32'h0);
    check(rd[20:16], 32'h0d);
    apb(1'b1, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST, 32'h3);
    apb(1'b1, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST, 32'hf);
    apb(1'b1, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_REQUEST, 32'h0);
    check(o_soft_pending, 32'h4004);
    apb(1'b0, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY, 32'h0);
    check(rd, 32'h8008);
    apb(1'b1, `CPUEXC_ADDR_SOFTWARE_INTERRUPT_SUMMARY, 32'h0);
    check(o_soft_pending, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
  endtask
  task t_exc;
    logic [10:0] e;
    for (int c = 0; c <= 'h15; c++) begin
      e = exp_of(c[4:0]);
      req(1'b1, c[4:0], 15'h0, 1'b0);
      check(o_vector, e[7:0]);
      check(o_to_firmware, e[10]);
      check(o_priority_level, c >= 'h13 ? 32'h1f : 32'h0d);
      check(o_saved_psl, c > 'h13 ? 32'h041f0000 : 32'h040d0000);
      if (e[9:8] != 2'h3) check(o_exc_type, e[9:8]);
      if (e[9:8] != 2'h3) check(o_saved_pc, {e[9:8] == 2'h0 ? 27'h200 : e[9] ? 27'h300 : 27'h100, c[4:0]});
    end
    req(1'b1, `CPUEXC_C_ACV, 15'h0, 1'b1);
    check({o_to_firmware, o_vector}, 32'h100);
    i_in_service <= 1'b0;
  endtask
  // Frame words are taken by index so a skipped slot shows as unknown
  task grab(input logic poke);
    frame = '{default: 'x};
    late_takes = 0;
    for (int i = 0; i < 14; i++) begin
      @(posedge i_clock);
      i_exc_valid <= poke && i == 3;
      if (o_exc_taken === 1'b1) late_takes++;
      if (o_frame_valid === 1'b1) frame[o_frame_index] = o_frame_data;
    end
  endtask
  task t_mc;
    logic [15:0] code;
    for (int k = 0; k <= 15; k++) begin
      code = k == 15 ? 16'h04 : {8'h0, MC_CODES[k*8 +: 8]};
      i_state_changed <= k[0];
      i_mc_param <= 32'h5a5a0000 + k;
      req(k == 15, `CPUEXC_C_ACV, k == 15 ? 15'h1008 : 15'h1 << k, 1'b0);
      check({o_exc_type, o_vector}, {22'h0, `CPUEXC_TYPE_ABORT, `CPUEXC_V_MCHK});
      check(o_saved_pc, {27'h300, `CPUEXC_C_ACV});
      check(o_priority_level, 32'h1f);
      grab(k == 15);
      check(late_takes, 32'h0);
      check(frame[0], `CPUEXC_MC_BYTE_COUNT);
      check(frame[1][31], !k[0]);
      check(frame[1][15:0], code);
      for (int p = 2; p < 10; p++) check(frame[p], 32'h5a5a0000 + k);
      check(frame[10], {27'h300, `CPUEXC_C_ACV});
      check(frame[11], `CPUEXC_PSL_RESET);
      if (k < 5) check(frame[1][31] && !frame[11][27], !k[0]);
      if (k == 11 || k == 12) check(frame[1][31] || frame[11][27], !k[0]);
    end
    apb(1'b0, `CPUEXC_ADDR_FRAME_CODE, 32'h0);
    check(rd, 32'h4);
    apb(1'b0, `CPUEXC_ADDR_FRAME_COUNT, 32'h0);
    check(rd, 32'h18);
    apb(1'b1, `CPUEXC_ADDR_FRAME_CLEAR, 32'h0);
    apb(1'b0, `CPUEXC_ADDR_FRAME_CODE, 32'h0);
    check(rd, 32'h0);
  endtask
  initial begin
    i_rst_n = 1'b0;
    {i_psel, i_penable, i_pwrite, i_exc_valid, i_in_service, i_state_changed} = 6'h0;
    {i_paddr, i_pwdata, i_exc_cause, i_mc_src} = '0;
    {i_cur_pc, i_next_pc, i_abort_pc, i_mc_param} = '0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_regs;
    t_exc;
    t_mc;
    complete_run;
  end
endmodule
bind cpuexc_unit cpuexc_unit_properties u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .i_exc_valid(i_exc_valid), .i_mc_src(i_mc_src), .i_cur_pc(i_cur_pc), .i_next_pc(i_next_pc),
  .i_abort_pc(i_abort_pc), .o_exc_taken(o_exc_taken), .o_exc_type(o_exc_type), .o_vector(o_vector),
  .o_to_firmware(o_to_firmware), .o_saved_pc(o_saved_pc), .o_priority_level(o_priority_level),
  .o_frame_valid(o_frame_valid), .o_frame_index(o_frame_index), .o_frame_data(o_frame_data));
